// ===== dv/psec_press_model.sv
// Press contact model: top dead center and upstroke derived from the enable.
// Assumes the press moves only while the enable is high and rests at top.
`timescale 1ns/1ps

module psec_press_model
#(
	parameter int TOP_CYCLES = 20
)
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic press_enable,
	output logic      top_dc,
	output logic      upstroke
);
	int run_cnt;

	// Press parks at top; top leaves once the drive runs, returns later
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			run_cnt  <= 0;
			top_dc   <= 1'b1;
			upstroke <= 1'b0;
		end
		else if (press_enable)
		begin
			run_cnt  <= run_cnt + 1;
			top_dc   <= (run_cnt >= TOP_CYCLES);
			upstroke <= (run_cnt >= TOP_CYCLES / 2);
		end
		else
		begin
			run_cnt  <= 0;
			upstroke <= 1'b0;
		end
	end
endmodule

// ===== dv/tb.sv
// Self-checking bench of the press stroke enable controller.
// Assumes a 100 MHz clock and a shortened millisecond tick.
`timescale 1ns/1ps

module tb;
	localparam int MS = 2;
	logic clk = 1'b0, reset_n = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic avs_waitrequest, rel_static = 1'b1, rel_start = 1'b1, rel_safety = 1'b1;
	logic stroke_cmd = 1'b0, rearm = 1'b0, top_dc, upstroke;
	logic press_enable, rearm_pending, rel_static_n;
	int miscompares = 0, checked = 0, cyc = 0;
	// Row: config, static, start gate, safety, expected enable
	logic [35:0] rows [7] = '{
		{32'h00, 3'b111, 1'b1}, {32'h00, 3'b011, 1'b0}, {32'h10, 3'b101, 1'b0},
		{32'h10, 3'b111, 1'b1}, {32'h21, 3'b110, 1'b0}, {32'h21, 3'b111, 1'b1},
		{32'h01, 3'b110, 1'b1}};

	always #5 clk = ~clk;

	psec_ctrl #(.MS_CYCLES(MS)) psec_ctrl_i (.clk(clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rel_static(rel_static), .rel_start(rel_start), .rel_safety(rel_safety),
		.stroke_cmd(stroke_cmd), .top_dc(top_dc), .upstroke(upstroke), .rearm(rearm),
		.press_enable(press_enable), .rearm_pending(rearm_pending),
		.rel_static_n(rel_static_n));

	psec_press_model psec_press_model_i (.clk(clk), .reset_n(reset_n),
		.press_enable(press_enable), .top_dc(top_dc), .upstroke(upstroke));

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until waitrequest is sampled low
	task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Stroke low then high; enable settled three edges later
	task automatic start;
		@(posedge clk);
		stroke_cmd <= 1'b0;
		repeat (2) @(posedge clk);
		stroke_cmd <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic pulse(input int ms);
		@(posedge clk);
		rearm <= 1'b1;
		repeat (ms * MS) @(posedge clk);
		rearm <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask

	// Safety and stroke dropped once the upstroke should mute them
	task automatic mute_run(input logic [31:0] c, input logic e);
		bus(1, 4'h0, c);
		start();
		repeat (10) @(posedge clk);
		rel_safety <= 1'b0;
		stroke_cmd <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(press_enable, e);
		@(posedge clk);
		rel_safety <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		chk(press_enable, 1'b0);
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			end_sim();
		end
	end

	initial
	begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		chk(press_enable, 1'b0);
		chk(rearm_pending, 1'b0);
		bus(0, 4'h4, 0);
		chk(q[1:0], 2'b00);
		bus(0, 4'h8, 0);
		chk(q, 32'h0);
		bus(1, 4'h0, 32'hffff_ffe0);
		bus(0, 4'h0, 0);
		chk(q, 32'h01ff_ffe0);
		$display("reset and bus test done");
		// **********************************************
		// Table of start conditions
		// **********************************************
		foreach (rows[i])
		begin
			bus(1, 4'h0, rows[i][35:4]);
			@(posedge clk);
			{rel_static, rel_start, rel_safety} <= rows[i][3:1];
			start();
			chk(press_enable, rows[i][0]);
			chk(rel_static_n, !rel_static);
			@(posedge clk);
			rel_start <= 1'b0;
			@(posedge clk);
			#1;
			chk(press_enable, rows[i][0]);
			@(posedge clk);
			rel_static <= 1'b0;
			repeat (2) @(posedge clk);
			#1;
			chk(press_enable, 1'b0);
			chk(rel_static_n, 1'b1);
			@(posedge clk);
			{rel_static, rel_start, rel_safety} <= 3'b111;
			$display("row %0d done", i);
		end
		// **********************************************
		// Top dead center, stroke modes
		// **********************************************
		bus(1, 4'h0, 32'h40);
		start();
		repeat (30) @(posedge clk);
		#1;
		chk(press_enable, 1'b0);
		bus(1, 4'h0, 32'h81);
		start();
		@(posedge clk);
		stroke_cmd <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(press_enable, 1'b1);
		repeat (30) @(posedge clk);
		#1;
		chk(press_enable, 1'b0);
		bus(1, 4'h0, 32'h01);
		start();
		@(posedge clk);
		stroke_cmd <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(press_enable, 1'b0);
		$display("stroke test done");
		// **********************************************
		// Upstroke muting
		// **********************************************
		mute_run(32'h1221, 1'b1);
		bus(0, 4'h4, 0);
		chk(q, 32'h10);
		mute_run(32'h1121, 1'b0);
		mute_run(32'h0221, 1'b0);
		$display("muting test done");
		// **********************************************
		// Restart lock, policy always
		// **********************************************
		bus(1, 4'h0, 32'h07);
		#1;
		chk(rearm_pending, 1'b1);
		start();
		chk(press_enable, 1'b0);
		pulse(50);
		chk(rearm_pending, 1'b1);
		pulse(110);
		chk(rearm_pending, 1'b0);
		start();
		chk(press_enable, 1'b1);
		repeat (30) @(posedge clk);
		#1;
		chk(press_enable, 1'b0);
		chk(rearm_pending, 1'b1);
		pulse(110);
		start();
		chk(press_enable, 1'b1);
		@(posedge clk);
		stroke_cmd <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(press_enable, 1'b0);
		chk(rearm_pending, 1'b1);
		pulse(110);
		start();
		chk(press_enable, 1'b1);
		$display("restart lock test done");
		// **********************************************
		// Reset in mid-run
		// **********************************************
		@(posedge clk);
		reset_n <= 1'b0;
		#1;
		chk(press_enable, 1'b0);
		chk(rearm_pending, 1'b0);
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(press_enable, 1'b0);
		bus(0, 4'h4, 0);
		chk(q, 32'h0);
		bus(1, 4'h0, 32'h07);
		#1;
		chk(rearm_pending, 1'b1);
		$display("mid-run reset test done");
		end_sim();
	end
endmodule

// ===== hw/psec_ctrl.sv
// Press stroke enable controller, setup and single-stroke variants.
// Assumes all release, cam and restart inputs are synchronous to clk,
// driven by neighbouring logic; configured over Avalon-MM.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "psec_params.svh"

module psec_ctrl
#(
	parameter int MS_CYCLES = `PSEC_MS_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rel_static,
	input  wire logic        rel_start,
	input  wire logic        rel_safety,
	input  wire logic        stroke_cmd,
	input  wire logic        top_dc,
	input  wire logic        upstroke,
	input  wire logic        rearm,
	output logic             press_enable,
	output logic             rearm_pending,
	output logic             rel_static_n
);

	localparam int TW = $clog2(MS_CYCLES);
	localparam int CW = $bits(psec_pkg::psec_cfg_t);

	psec_pkg::psec_cfg_t   cfg;
	psec_pkg::psec_pulse_t ps;
	logic [TW-1:0]         tick_cnt;
	logic                  ms_tick;
	logic                  ack;
	logic [31:0]           cfg_w;
	logic [31:0]           next_cfg_w;
	logic [31:0]           stat_w;
	logic                  stroke_q;
	logic                  top_q;
	logic                  rel3_q;
	logic                  up_q;
	logic                  stroke_rise;
	logic                  top_rise;
	logic                  up_rise;
	logic [12:0]           mute_s_eff;
	logic [22:0]           mute_lim;
	logic [22:0]           mute_ms;
	logic                  mute_exp;
	logic                  mute_on;
	logic                  mute_stroke;
	logic                  rel3_on;
	logic                  stop_rel1;
	logic                  stop_rel3;
	logic                  stop_stroke;
	logic                  stop_top;
	logic                  stop_any;
	logic                  idle_rel3;
	logic                  lock_trig;
	logic                  start_ok;
	logic                  top_park;
	logic                  pend_q;
	logic [14:0]           pw_ms;
	logic [14:0]           pw_min;
	logic                  pulse_ok;

	// ****************************************
	// Millisecond tick
	// ****************************************

	// Free-running so pulse widths are judged to within one tick
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			tick_cnt <= '0;
		else if (ms_tick)
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 1'b1;
	end

	assign ms_tick = (tick_cnt == TW'(MS_CYCLES - 1));

	// ****************************************
	// Register slave
	// ****************************************

	// One wait state on every access, then the answer
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & ~ack;
	end

	assign cfg_w = 32'(cfg);

	genvar b;
	for (b = 0; b < 4; b++)
	begin : g_lane
		assign next_cfg_w[8*b +: 8] = avs_byteenable[b] ? avs_writedata[8*b +: 8]
		                                                : cfg_w[8*b +: 8];
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cfg <= psec_pkg::psec_cfg_t'(`PSEC_CFG_RST);
		else if (avs_write && ack && avs_address == `PSEC_CFG_OFS)
			cfg <= psec_pkg::psec_cfg_t'(next_cfg_w[CW-1:0]);
	end

	always_comb
	begin
		stat_w = 32'h00000000;
		stat_w[`PSEC_ST_EN] = press_enable;
		stat_w[`PSEC_ST_PEND] = rearm_pending;
		stat_w[`PSEC_ST_MUTE] = mute_on;
		stat_w[`PSEC_ST_MEXP] = mute_exp;
		stat_w[`PSEC_ST_PARK] = top_park;
	end

	// Unmapped addresses read as zero and ignore writes
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !ack)
		begin
			case (avs_address)
				`PSEC_CFG_OFS:  avs_readdata <= cfg_w;
				`PSEC_STAT_OFS: avs_readdata <= stat_w;
				default:        avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// Input history and edges
	// ****************************************

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stroke_q <= 1'b1;
			top_q    <= 1'b1;
			rel3_q   <= 1'b0;
			up_q     <= 1'b0;
		end
		else
		begin
			stroke_q <= stroke_cmd;
			top_q    <= top_dc;
			rel3_q   <= rel_safety;
			up_q     <= upstroke;
		end
	end

	// Stroke and top history reset high so a level held through reset is no edge; safety and upstroke history reset low
	assign stroke_rise = stroke_cmd & ~stroke_q;
	assign top_rise    = top_dc & ~top_q;
	assign up_rise     = upstroke & ~up_q;

	// ****************************************
	// Upstroke muting
	// ****************************************

	assign mute_s_eff = (cfg.mute_s > 13'(`PSEC_MUTE_MAX_S)) ? 13'(`PSEC_MUTE_MAX_S)
	                                                         : cfg.mute_s;
	assign mute_lim = {10'h000, mute_s_eff} * 23'(`PSEC_MS_PER_S);

	// Restarts on every upstroke rise; no plausibility check is made
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mute_ms  <= '0;
			mute_exp <= 1'b0;
		end
		else if (up_rise)
		begin
			mute_ms  <= '0;
			mute_exp <= 1'b0;
		end
		else if (upstroke && ms_tick && !mute_exp)
		begin
			mute_ms <= mute_ms + 23'd1;
			if (mute_ms + 23'd1 >= mute_lim)
				mute_exp <= 1'b1;
		end
	end

	assign mute_on = cfg.single && (mute_s_eff != 13'h0000)
	                 && (cfg.mute_mode != psec_pkg::MUTE_OFF)
	                 && press_enable && upstroke && !mute_exp;
	assign mute_stroke = mute_on && (cfg.mute_mode != psec_pkg::MUTE_REL3);

	// ****************************************
	// Stop causes and restart lock
	// ****************************************

	assign rel3_on = cfg.single & cfg.rel3_en;

	assign stop_rel1 = press_enable & ~rel_static;
	assign stop_rel3 = press_enable & rel3_on & ~rel_safety & ~mute_on;
	// Start-only mode exists in the single-stroke variant only
	assign stop_stroke = press_enable & ~stroke_cmd & ~mute_stroke
	                     & ~(cfg.single & cfg.start_only);
	assign stop_top = press_enable & top_rise & (cfg.single | cfg.guard);
	assign stop_any = stop_rel1 | stop_rel3 | stop_stroke | stop_top;

	// Safety release falling while stopped still locks, unless parked at top
	assign idle_rel3 = ~press_enable & rel3_on & rel3_q & ~rel_safety
	                   & ~(cfg.ign_rel3_top & top_park);

	always_comb
	begin
		case (cfg.lock)
			psec_pkg::LOCK_NONE:       lock_trig = 1'b0;
			psec_pkg::LOCK_ANY_LOW:    lock_trig = stop_rel1 | stop_rel3 | stop_stroke
			                                       | idle_rel3;
			psec_pkg::LOCK_LOW_OR_TOP: lock_trig = stop_rel1 | stop_rel3 | stop_top
			                                       | idle_rel3;
			psec_pkg::LOCK_REL_LOW:    lock_trig = stop_rel1 | stop_rel3 | idle_rel3;
			default:                   lock_trig = stop_any | idle_rel3;
		endcase
	end

	// ****************************************
	// Rearm pulse check
	// ****************************************

	assign pw_min = cfg.pulse_350 ? 15'(`PSEC_PULSE_MIN_B_MS)
	                              : 15'(`PSEC_PULSE_MIN_A_MS);

	// A restart held high out of reset must fall first
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ps    <= psec_pkg::PS_WAIT_LOW;
			pw_ms <= '0;
		end
		else
		begin
			case (ps)
				psec_pkg::PS_WAIT_LOW:
				begin
					if (!rearm)
						ps <= psec_pkg::PS_ARMED;
				end
				psec_pkg::PS_ARMED:
				begin
					if (rearm)
					begin
						ps    <= psec_pkg::PS_HIGH;
						pw_ms <= '0;
					end
				end
				psec_pkg::PS_HIGH:
				begin
					if (!rearm)
						ps <= psec_pkg::PS_ARMED;
					else if (ms_tick)
					begin
						if (pw_ms == 15'(`PSEC_PULSE_MAX_MS))
							ps <= psec_pkg::PS_WAIT_LOW;
						else
							pw_ms <= pw_ms + 15'd1;
					end
				end
				default: ps <= psec_pkg::PS_WAIT_LOW;
			endcase
		end
	end

	assign pulse_ok = (ps == psec_pkg::PS_HIGH) && !rearm && (pw_ms >= pw_min);

	// A new lock in the cycle of a valid pulse keeps the lock set
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pend_q <= 1'b1;
		else if (lock_trig)
			pend_q <= 1'b1;
		else if (pulse_ok)
			pend_q <= 1'b0;
	end

	assign rearm_pending = pend_q & (cfg.lock != psec_pkg::LOCK_NONE);

	// ****************************************
	// Press enable
	// ****************************************

	// Start-gate release is read only while the enable is low
	assign start_ok = ~press_enable & ~rearm_pending & rel_static
	                  & (~cfg.rel2_en | rel_start) & (~rel3_on | rel_safety)
	                  & stroke_rise;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			press_enable <= 1'b0;
		else if (start_ok)
			press_enable <= 1'b1;
		else if (stop_any)
			press_enable <= 1'b0;
	end

	// Marks a regular stop at top until the next start
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			top_park <= 1'b0;
		else if (stop_top)
			top_park <= 1'b1;
		else if (start_ok)
			top_park <= 1'b0;
	end

	assign rel_static_n = ~rel_static;

	// ****************************************
	// Assertions
	// ****************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_top_stop;
		press_enable && top_rise && (cfg.single || cfg.guard);
	endsequence

	sequence s_fresh_start;
		$rose(press_enable) ##0 (cfg.lock == $past(cfg.lock));
	endsequence

	a_static_drop: assert property (!rel_static |=> !press_enable)
		else $error("enable stayed high after static release low");
	a_inv_release: assert property (rel_static_n == !rel_static)
		else $error("inverted release not complement");
	a_enable_clear: assert property ($rose(press_enable) |-> !$past(rearm_pending))
		else $error("enable rose while rearm pending");
	a_top_drop: assert property (s_top_stop |=> !press_enable)
		else $error("enable held through top rise");
	a_none_free: assert property (cfg.lock == psec_pkg::LOCK_NONE |-> !rearm_pending)
		else $error("pending with lock policy none");
	a_start_gate: assert property (s_fresh_start ##0 $past(cfg.rel2_en) |-> $past(rel_start))
		else $error("enable rose with start gate low");
	a_start_edge: assert property ($rose(press_enable)
		|-> $past(stroke_cmd) && !$past(stroke_cmd, 2) && $past(rel_static))
		else $error("enable rose without stroke edge");
	a_safety_rise: assert property (s_fresh_start ##0 $past(rel3_on) |-> $past(rel_safety))
		else $error("enable rose with safety release low");
	a_step_lock: assert property (stop_stroke && cfg.lock == psec_pkg::LOCK_ALWAYS
		|=> rearm_pending [*2])
		else $error("stroke stop did not lock");
	a_pulse_clear: assert property ($fell(pend_q)
		|-> $past(pulse_ok) && $past(pw_ms) >= 15'(`PSEC_PULSE_MIN_A_MS))
		else $error("lock cleared without valid pulse");
	a_mute_hold: assert property (mute_on && mute_stroke && rel_static && !top_rise
		|=> press_enable)
		else $error("muted inputs dropped the enable");

endmodule

// ===== hw/psec_params.svh
// Constants of the press stroke enable controller: offsets, reset values
// and timing figures. Included by the controller; definitions only.
`ifndef PSEC_PARAMS_SVH
`define PSEC_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define PSEC_CFG_OFS    4'h0
`define PSEC_STAT_OFS   4'h4

// Configuration reset: setup variant, no restart lock, everything off
`define PSEC_CFG_RST    25'h0000000

// Status word bit positions
`define PSEC_ST_EN      0
`define PSEC_ST_PEND    1
`define PSEC_ST_MUTE    2
`define PSEC_ST_MEXP    3
`define PSEC_ST_PARK    4

// Timing, each figure in its own unit
`define PSEC_CLK_NS         10
`define PSEC_MS_NS          1000000
`define PSEC_MS_CYCLES      (`PSEC_MS_NS / `PSEC_CLK_NS)
`define PSEC_PULSE_MIN_A_MS 100
`define PSEC_PULSE_MIN_B_MS 350
`define PSEC_PULSE_MAX_MS   30000
`define PSEC_MUTE_MAX_S     7200
`define PSEC_MS_PER_S       1000

`endif

// ===== hw/psec_pkg.sv
// Types of the press stroke enable controller.
// Assumes the field layout of the configuration word given here.
package psec_pkg;

	typedef enum logic [2:0]
	{
		LOCK_NONE,
		LOCK_ANY_LOW,
		LOCK_LOW_OR_TOP,
		LOCK_ALWAYS,
		LOCK_REL_LOW
	} psec_lock_t;

	typedef enum logic [1:0]
	{
		MUTE_OFF,
		MUTE_REL3,
		MUTE_BOTH
	} psec_mute_t;

	typedef enum logic [1:0]
	{
		PS_WAIT_LOW,
		PS_ARMED,
		PS_HIGH
	} psec_pulse_t;

	// Configuration word, bit 0 upward from the bottom of the list
	typedef struct packed
	{
		logic [12:0] mute_s;       // 24:12
		logic        ign_rel3_top; // 11
		logic        pulse_350;    // 10
		psec_mute_t  mute_mode;    // 9:8
		logic        start_only;   // 7
		logic        guard;        // 6
		logic        rel3_en;      // 5
		logic        rel2_en;      // 4
		psec_lock_t  lock;         // 3:1
		logic        single;       // 0
	} psec_cfg_t;

endpackage
